// File: design/s_line_consts.svh
// constants for the s-interface line and multiframe logic
// assumes one 25 MHz core clock and a recovered bit strobe
`ifndef S_LINE_CONSTS_SVH
`define S_LINE_CONSTS_SVH

// clock and frame timing
`define CORE_CLK_HZ 25000000
`define FRAME_RATE_HZ 4000
`define FRAME_BITS 6'd48
`define BIT_CYCLES (`CORE_CLK_HZ / (`FRAME_RATE_HZ * 48))

// bit positions in the received frame
`define POS_FRAME 6'd0
`define POS_LAST 6'd47
`define POS_E0 6'd10
`define POS_E1 6'd22
`define POS_E2 6'd33
`define POS_E3 6'd44
`define POS_FA_RX 6'd12
`define POS_M_RX 6'd24
`define POS_S_RX 6'd35

// bit positions in the transmitted frame
`define POS_FA_TX 6'd13
`define POS_D0 6'd11
`define POS_D1 6'd24
`define POS_D2 6'd35
`define POS_D3 6'd46
`define TX_OFFSET 6'd2

// thresholds and multiframe shape
`define ANY_SIGNAL_MARKS 2'd3
`define FRAME_LOCK_MISSES 2'd2
`define MF_LAST_FRAME 5'd19
`define MF_SUB_LEN 3'd5
`define MF_GOOD_NEEDED 2'd3
`define MF_BAD_LIMIT 2'd3

`endif

// File: design/s_line_pkg.sv
// types shared by the s-interface line logic
// constants live in s_line_consts.svh
package s_line_pkg;

   // one line symbol as a pair of mark levels
   typedef struct packed {
      logic markHigh;
      logic markLow;
   } line_sym_t;

   // multiframe alignment states, one-hot
   typedef enum logic [2:0] {
      MF_OFF = 3'h1,
      MF_HUNT = 3'h2,
      MF_SYNC = 3'h4
   } mf_state_t;

endpackage

// File: design/s_line_unit.sv
// line coding, frame alignment, collision check and multiframe sync
// assumes a recovered bit strobe on core_clk and comparator pins from the line
`timescale 1ns/100ps
`include "s_line_consts.svh"

// Functional notes
// R1 - a binary one is a space and a binary zero is a mark of either polarity, both ways.
// R2 - successive zeros go out as marks of alternating polarity; the code repeats the last polarity for the framing zero at bit 0.
// R3 - a mark with the same polarity as the previous mark is flagged as a code violation.
// R4 - code violations locate the frame boundary and give frame alignment.
// R5 - a frame counts as any signal only with at least three marks in it.
// R6 - both directions use 48-bit frames.
// R7 - frames run at 4000 per second, set by the far end's bit timing.
// R8 - the frame layout is the same for point-to-point and multipoint.
// R9 - each echoed E bit is compared with the D bit sent to detect contention; the code compares only while frame lock is held.
// R10 - FA and M are watched only while multiframing is enabled and activation is F6 or F7.
// R11 - three good multiframes in a row set the synced flag and pulse a change of state.
// R12 - S bits are collected only from the multiframe after sync is reached.
// R13 - while multiframing, Q bits go out in transmit FA positions timed to the received frame.
// R14 - three bad multiframes, leaving F6/F7 or disabling drops sync with a change of state.
// R15 - a multiframe is twenty frames, FA one in frames 1, 6, 11, 16 and M one in frame 1.
module s_line_unit (
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic clkEn,
   // receive line comparators and recovered bit timing
   input wire s_line_pkg::line_sym_t rxPins,
   input wire logic bitStrobe,
   // transmit line drive
   output s_line_pkg::line_sym_t txPins,
   // decoded receive stream
   output logic rxBit,
   output logic rxBitValid,
   output logic [5:0] rxBitPos,
   output logic frameLocked,
   output logic anySignal,
   output logic codeViolation,
   output logic collision,
   // transmit stream from the user
   input wire logic txBitIn,
   output logic txBitTake,
   // multiframe control and status
   input wire logic mfEnable,
   input wire logic actF6F7,
   input wire logic [4:0] qBits,
   output logic mfSynced,
   output logic mfChange,
   output logic [4:0] sWord,
   output logic sWordValid,
   output logic sFirstWord
);

   // three-stage pin synchroniser, update when stages two and three agree
   s_line_pkg::line_sym_t pinS1_reg, pinS2_reg, pinS3_reg, pinStable_reg, pinStable_next;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pinS1_reg <= '0;
         pinS2_reg <= '0;
         pinS3_reg <= '0;
      end else if (clkEn) begin
         pinS1_reg <= rxPins;
         pinS2_reg <= pinS1_reg;
         pinS3_reg <= pinS2_reg;
      end
   end
   always_comb begin
      pinStable_next = (pinS2_reg == pinS3_reg) ? pinS3_reg : pinStable_reg;
   end

   // receive decode and frame alignment state
   logic [5:0] rxPos_reg, rxPos_next;
   logic lastPol_reg, lastPol_next, anyMark_reg, anyMark_next;
   logic [1:0] marks_reg, marks_next, miss_reg, miss_next;
   logic lock_reg, lock_next, sawF_reg, sawF_next, anySig_reg, anySig_next;
   logic rxBit_reg, rxBit_next, rxVal_reg, rxVal_next, cv_reg, cv_next;
   logic isMark, markPol, violation, frameEnd;

   // line symbol to binary, violation check and frame counting
   always_comb begin
      // R1 mark is zero
      isMark = pinStable_reg.markHigh ^ pinStable_reg.markLow;
      markPol = pinStable_reg.markHigh;
      // R3 same polarity repeat
      violation = bitStrobe && isMark && anyMark_reg && (markPol == lastPol_reg);
      // R7 R8 strobe-paced, one layout
      frameEnd = bitStrobe && (rxPos_reg == `POS_LAST);
      rxPos_next = rxPos_reg;
      lastPol_next = lastPol_reg;
      anyMark_next = anyMark_reg;
      marks_next = marks_reg;
      miss_next = miss_reg;
      lock_next = lock_reg;
      sawF_next = sawF_reg;
      anySig_next = anySig_reg;
      rxBit_next = rxBit_reg;
      rxVal_next = bitStrobe;
      cv_next = violation;
      if (bitStrobe) begin
         rxBit_next = !isMark;
         if (isMark) begin
            lastPol_next = markPol;
            anyMark_next = 1'b1;
            if (marks_reg != `ANY_SIGNAL_MARKS)
               marks_next = marks_reg + 2'd1;
         end
         rxPos_next = frameEnd ? `POS_FRAME : rxPos_reg + 6'd1;
         // R4 violation marks bit zero
         if (violation && (rxPos_reg == `POS_FRAME))
            sawF_next = 1'b1;
         else if (violation && !lock_reg)
            rxPos_next = 6'd1;
         if (frameEnd) begin
            // R5 three marks per frame
            anySig_next = (marks_next == `ANY_SIGNAL_MARKS);
            marks_next = 2'd0;
            sawF_next = 1'b0;
            if (sawF_reg) begin
               lock_next = 1'b1;
               miss_next = 2'd0;
            end else if (miss_reg == `FRAME_LOCK_MISSES - 2'd1) begin
               lock_next = 1'b0;
               miss_next = 2'd0;
            end else begin
               miss_next = miss_reg + 2'd1;
            end
         end
      end
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pinStable_reg <= '0;
         rxPos_reg <= `POS_FRAME;
         lastPol_reg <= 1'b0;
         anyMark_reg <= 1'b0;
         marks_reg <= 2'd0;
         miss_reg <= 2'd0;
         lock_reg <= 1'b0;
         sawF_reg <= 1'b0;
         anySig_reg <= 1'b0;
         rxBit_reg <= 1'b1;
         rxVal_reg <= 1'b0;
         cv_reg <= 1'b0;
      end else if (clkEn) begin
         pinStable_reg <= pinStable_next;
         rxPos_reg <= rxPos_next;
         lastPol_reg <= lastPol_next;
         anyMark_reg <= anyMark_next;
         marks_reg <= marks_next;
         miss_reg <= miss_next;
         lock_reg <= lock_next;
         sawF_reg <= sawF_next;
         anySig_reg <= anySig_next;
         rxBit_reg <= rxBit_next;
         rxVal_reg <= rxVal_next;
         cv_reg <= cv_next;
      end
   end

   // multiframe alignment state
   s_line_pkg::mf_state_t mf_reg, mf_next;
   logic [4:0] mfFrame_reg, mfFrame_next, sShift_reg, sShift_next, sWord_reg, sWord_next;
   logic [1:0] good_reg, good_next, bad_reg, bad_next;
   logic faRx_reg, faRx_next, mRx_reg, mRx_next, sRx_reg, sRx_next;
   logic mfBad_reg, mfBad_next, sOn_reg, sOn_next, chg_reg, chg_next;
   logic sVal_reg, sVal_next, sFirst_reg, sFirst_next;
   logic faExp, mExp, frameOk, mfEnd, subEnd;

   // FA/M checking, sync counting and S-bit collection
   always_comb begin
      // R15 expected FA and M
      faExp = (mfFrame_reg == 5'd0) || (mfFrame_reg == 5'd5) || (mfFrame_reg == 5'd10)
         || (mfFrame_reg == 5'd15);
      mExp = (mfFrame_reg == 5'd0);
      frameOk = (faRx_reg == faExp) && (mRx_reg == mExp);
      mfEnd = (mfFrame_reg == `MF_LAST_FRAME);
      subEnd = (mfFrame_reg == 5'd4) || (mfFrame_reg == 5'd9) || (mfFrame_reg == 5'd14)
         || mfEnd;
      mf_next = mf_reg;
      mfFrame_next = mfFrame_reg;
      sShift_next = sShift_reg;
      sWord_next = sWord_reg;
      good_next = good_reg;
      bad_next = bad_reg;
      faRx_next = faRx_reg;
      mRx_next = mRx_reg;
      sRx_next = sRx_reg;
      mfBad_next = mfBad_reg;
      sOn_next = sOn_reg;
      chg_next = 1'b0;
      sVal_next = 1'b0;
      sFirst_next = sFirst_reg;
      if (bitStrobe && rxPos_reg == `POS_FA_RX)
         faRx_next = !isMark;
      if (bitStrobe && rxPos_reg == `POS_M_RX)
         mRx_next = !isMark;
      if (bitStrobe && rxPos_reg == `POS_S_RX)
         sRx_next = !isMark;
      case (mf_reg)
         s_line_pkg::MF_OFF: begin
            // R10 watch only when enabled in F6/F7
            if (mfEnable && actF6F7) begin
               mf_next = s_line_pkg::MF_HUNT;
               good_next = 2'd0;
               mfBad_next = 1'b0;
            end
         end
         s_line_pkg::MF_HUNT: begin
            if (!(mfEnable && actF6F7)) begin
               mf_next = s_line_pkg::MF_OFF;
            end else if (frameEnd && lock_reg) begin
               mfFrame_next = mfEnd ? 5'd0 : mfFrame_reg + 5'd1;
               if (faRx_reg && mRx_reg) begin
                  // realign on the frame-one pattern
                  mfFrame_next = 5'd1;
                  if (!mExp || mfBad_reg)
                     good_next = 2'd0;
                  mfBad_next = 1'b0;
               end else if (!frameOk) begin
                  good_next = 2'd0;
                  mfBad_next = 1'b1;
               end else if (mfEnd) begin
                  // R11 three good multiframes
                  if (!mfBad_reg && good_reg == `MF_GOOD_NEEDED - 2'd1) begin
                     mf_next = s_line_pkg::MF_SYNC;
                     chg_next = 1'b1;
                     bad_next = 2'd0;
                     sOn_next = 1'b0;
                  end else if (!mfBad_reg) begin
                     good_next = good_reg + 2'd1;
                  end
                  mfBad_next = 1'b0;
               end
            end
         end
         s_line_pkg::MF_SYNC: begin
            // R14 loss on exit, disable or three bad
            if (!(mfEnable && actF6F7)) begin
               mf_next = s_line_pkg::MF_OFF;
               chg_next = 1'b1;
            end else if (frameEnd && lock_reg) begin
               mfFrame_next = mfEnd ? 5'd0 : mfFrame_reg + 5'd1;
               // R12 collect from next multiframe on
               if (mfFrame_reg == 5'd0)
                  sOn_next = 1'b1;
               if (sOn_next) begin
                  sShift_next = {sShift_reg[3:0], sRx_reg};
                  if (subEnd) begin
                     sWord_next = sShift_next;
                     sVal_next = 1'b1;
                     sFirst_next = (mfFrame_reg == 5'd4);
                  end
               end
               if (mfEnd) begin
                  mfBad_next = 1'b0;
                  if (mfBad_reg || !frameOk) begin
                     if (bad_reg == `MF_BAD_LIMIT - 2'd1) begin
                        mf_next = s_line_pkg::MF_HUNT;
                        chg_next = 1'b1;
                        sVal_next = 1'b0; // no word once sync is lost
                        good_next = 2'd0;
                     end else begin
                        bad_next = bad_reg + 2'd1;
                     end
                  end else begin
                     bad_next = 2'd0;
                  end
               end else if (!frameOk) begin
                  mfBad_next = 1'b1;
               end
            end
         end
         default: mf_next = s_line_pkg::MF_OFF;
      endcase
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         mf_reg <= s_line_pkg::MF_OFF;
         mfFrame_reg <= 5'd0;
         sShift_reg <= 5'd0;
         sWord_reg <= 5'd0;
         good_reg <= 2'd0;
         bad_reg <= 2'd0;
         faRx_reg <= 1'b0;
         mRx_reg <= 1'b0;
         sRx_reg <= 1'b0;
         mfBad_reg <= 1'b0;
         sOn_reg <= 1'b0;
         chg_reg <= 1'b0;
         sVal_reg <= 1'b0;
         sFirst_reg <= 1'b0;
      end else if (clkEn) begin
         mf_reg <= mf_next;
         mfFrame_reg <= mfFrame_next;
         sShift_reg <= sShift_next;
         sWord_reg <= sWord_next;
         good_reg <= good_next;
         bad_reg <= bad_next;
         faRx_reg <= faRx_next;
         mRx_reg <= mRx_next;
         sRx_reg <= sRx_next;
         mfBad_reg <= mfBad_next;
         sOn_reg <= sOn_next;
         chg_reg <= chg_next;
         sVal_reg <= sVal_next;
         sFirst_reg <= sFirst_next;
      end
   end

   // transmit state
   logic [5:0] txPos_reg, txPos_next;
   logic txPol_reg, txPol_next, lastD_reg, lastD_next, col_reg, col_next;
   s_line_pkg::line_sym_t txSym_reg, txSym_next;
   logic txBitNow, qBit, isDPos, isEPos;

   // encoder, Q insertion and E/D contention check
   always_comb begin
      // R13 Q bits in transmit FA
      case (mf_reg)
         s_line_pkg::MF_SYNC: begin
            case (mfFrame_reg)
               5'd0: qBit = qBits[3];
               5'd5: qBit = qBits[2];
               5'd10: qBit = qBits[1];
               5'd15: qBit = qBits[0];
               default: qBit = 1'b0;
            endcase
         end
         s_line_pkg::MF_HUNT: qBit = qBits[4];
         default: qBit = 1'b0;
      endcase
      isDPos = (txPos_reg == `POS_D0) || (txPos_reg == `POS_D1) || (txPos_reg == `POS_D2)
         || (txPos_reg == `POS_D3);
      isEPos = (rxPos_reg == `POS_E0) || (rxPos_reg == `POS_E1) || (rxPos_reg == `POS_E2)
         || (rxPos_reg == `POS_E3);
      txBitNow = txBitIn;
      if (txPos_reg == `POS_FRAME)
         txBitNow = 1'b0;
      else if (txPos_reg == `POS_FA_TX && mf_reg != s_line_pkg::MF_OFF)
         txBitNow = qBit;
      txPos_next = txPos_reg;
      txPol_next = txPol_reg;
      txSym_next = txSym_reg;
      lastD_next = lastD_reg;
      col_next = 1'b0;
      if (bitStrobe) begin
         // R6 frame timed from the received frame
         txPos_next = (rxPos_reg == `TX_OFFSET) ? 6'd1 :
            ((txPos_reg == `POS_LAST) ? `POS_FRAME : txPos_reg + 6'd1);
         // R1 one is a space
         txSym_next = '0;
         if (!txBitNow) begin
            if (txPos_reg == `POS_FRAME) begin
               // framing mark repeats polarity on purpose
               txSym_next.markHigh = txPol_reg;
               txSym_next.markLow = !txPol_reg;
            end else begin
               // R2 alternate mark polarity
               txSym_next.markHigh = !txPol_reg;
               txSym_next.markLow = txPol_reg;
               txPol_next = !txPol_reg;
            end
         end
         if (isDPos)
            lastD_next = txBitNow;
         // R9 echo compare
         if (lock_reg && isEPos && (!isMark != lastD_reg))
            col_next = 1'b1;
      end
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         txPos_reg <= `POS_FRAME;
         txPol_reg <= 1'b0;
         txSym_reg <= '0;
         lastD_reg <= 1'b1;
         col_reg <= 1'b0;
      end else if (clkEn) begin
         txPos_reg <= txPos_next;
         txPol_reg <= txPol_next;
         txSym_reg <= txSym_next;
         lastD_reg <= lastD_next;
         col_reg <= col_next;
      end
   end

   // outputs
   assign txPins = txSym_reg;
   assign txBitTake = clkEn && bitStrobe && (txPos_reg != `POS_FRAME)
      && !(txPos_reg == `POS_FA_TX && mf_reg != s_line_pkg::MF_OFF);
   assign rxBit = rxBit_reg;
   assign rxBitValid = rxVal_reg;
   assign rxBitPos = rxPos_reg;
   assign frameLocked = lock_reg;
   assign anySignal = anySig_reg;
   assign codeViolation = cv_reg;
   assign collision = col_reg;
   assign mfSynced = (mf_reg == s_line_pkg::MF_SYNC);
   assign mfChange = chg_reg;
   assign sWord = sWord_reg;
   assign sWordValid = sVal_reg;
   assign sFirstWord = sFirst_reg;

endmodule // s_line_unit

// File: dv/s_line_unit_asserts.sv
// port checker for the s-interface line unit
// assumes binding onto s_line_unit, one clock domain
`timescale 1ns/100ps
module s_line_unit_asserts (
   // clock and reset
   input logic core_clk,
   input logic arst_n,
   // watched inputs
   input logic clkEn,
   input logic bitStrobe,
   input logic mfEnable,
   input logic actF6F7,
   // watched outputs
   input s_line_pkg::line_sym_t txPins,
   input logic rxBit,
   input logic rxBitValid,
   input logic frameLocked,
   input logic anySignal,
   input logic codeViolation,
   input logic collision,
   input logic txBitTake,
   input logic mfSynced,
   input logic mfChange,
   input logic sWordValid,
   input logic sFirstWord
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   // line timing and coding
   AST_BIT_ANSWER: assert property ((bitStrobe && clkEn) |=> rxBitValid ##1 !rxBitValid)
      else $error("decoded bit not one cycle after strobe");
   AST_TX_SYMBOL: assert property (!(txPins.markHigh && txPins.markLow))
      else $error("both transmit marks driven");
   AST_TX_HOLD: assert property (!(bitStrobe && clkEn) |=> $stable(txPins))
      else $error("transmit symbol changed between strobes");
   AST_VIOL_MARK: assert property (codeViolation |-> rxBitValid && !rxBit)
      else $error("violation flagged off a mark");
   AST_ANY_FRAME: assert property ($changed(anySignal) |-> $past(bitStrobe) && $past(clkEn))
      else $error("signal flag moved without a strobe");
   AST_TAKE: assert property (txBitTake |-> bitStrobe && clkEn)
      else $error("user bit taken without strobe");
   AST_COLL_LOCK: assert property (collision |-> $past(frameLocked))
      else $error("collision without frame lock");

   // multiframe control
   AST_GATE: assert property (!(mfEnable && actF6F7) |-> ##[0:2] !mfSynced)
      else $error("multiframe sync held while disabled");
   AST_SYNC_GAIN: assert property ($rose(mfSynced) |-> mfChange
      && $past(mfEnable) && $past(actF6F7))
      else $error("sync gained without change pulse");
   AST_CHANGE_PULSE: assert property (mfChange |=> !mfChange)
      else $error("change flag longer than one cycle");
   AST_S_AFTER_SYNC: assert property (sWordValid |-> mfSynced)
      else $error("s word delivered while not synced");
   AST_SYNC_LOSS: assert property ($fell(mfSynced) |-> mfChange)
      else $error("sync lost without change pulse");

   // main scenarios reached
   COV_SYNC: cover property ($rose(mfSynced));
   COV_LOSS: cover property ($fell(mfSynced));
   COV_COLL: cover property (collision);
   COV_FIRST: cover property (sWordValid && sFirstWord);
endmodule // s_line_unit_asserts

// File: dv/s_line_nt.sv
// network terminator model: drives the receive line and bit strobe
// assumes the device transmit line is decoded at the same strobes
`timescale 1ns/100ps
module s_line_nt (
   // clock
   input logic core_clk,
   // line
   input s_line_pkg::line_sym_t txPins,
   output s_line_pkg::line_sym_t rxPins,
   output logic bitStrobe,
   // fault and mode controls
   input logic mfBad,
   input logic echoBad,
   input int quietZeros
);
   int frameNo = 0, pos, txPos = 0, txViol = 0, txBadLen = 0, qOnes = 0, qZeros = 0;
   logic bitNow, sNow, rxPol = 1'b0, txPol = 1'b0, lastD = 1'b1;

   function automatic logic frameBit(int p);
      int k = frameNo % 20;
      if (p == 0) return 1'b0;
      if (quietZeros > 0) return !(p >= 2 && p < 2 + quietZeros);
      if (p == 12) return k % 5 == 0;
      if (p == 24) return (k == 0) ^ mfBad;
      if (p == 35) return sNow;
      if (p inside {10, 22, 33, 44}) return lastD ^ echoBad;
      return p % 3 != 0;
   endfunction

   initial begin
      bitStrobe = 1'b0;
      rxPins = 2'b00;
      forever begin
         sNow = 1'($urandom);
         for (pos = 0; pos < 48; pos++) begin
            bitNow = frameBit(pos);
            if (!bitNow && pos != 0) rxPol = !rxPol;
            rxPins = bitNow ? 2'b00 : {rxPol, !rxPol};
            // symbol needs four edges through the pin synchroniser
            repeat (4) @(negedge core_clk);
            bitStrobe = 1'b1;
            @(negedge core_clk);
            bitStrobe = 1'b0;
         end
         frameNo++;
      end
   end

   // decode transmit marks and frame length
   always @(posedge core_clk) if (bitStrobe) begin
      if (txPins != 2'b00) begin
         if (txPins.markHigh == txPol) begin
            if (txViol > 0 && txPos != 48) txBadLen++;
            txViol++;
            txPos = 0;
         end
         txPol = txPins.markHigh;
      end
      if (txPos == 13) begin
         if (txPins == 2'b00) qOnes++;
         else qZeros++;
      end
      if (txPos inside {11, 24, 35, 46}) lastD = txPins == 2'b00;
      txPos++;
   end
endmodule // s_line_nt

// File: dv/tb_top.sv
// self-checking bench for the s-interface line unit
// assumes inputs change at negedge; the partner owns line and strobe
`timescale 1ns/100ps
module tb_top;
   logic core_clk = 1'b0, arst_n = 1'b0, clkEn = 1'b1, txBitIn = 1'b1;
   logic mfEnable = 1'b0, actF6F7 = 1'b1, mfBad = 1'b0, echoBad = 1'b0;
   logic [4:0] qBits = 5'h15;
   int quietZeros = 0, n_fail = 0, checks_done = 0, cyc = 0, nColl = 0, nChange = 0;
   int q1, q0, bad0, n, ep;
   logic armed = 1'b0, ev, eb;
   logic expQ[$], violQ[$], sQ[$];
   int sFrQ[$], posQ[$];
   s_line_pkg::line_sym_t rxPins, txPins;
   logic bitStrobe, rxBit, rxBitValid, frameLocked, anySignal, codeViolation, collision;
   logic txBitTake, mfSynced, mfChange, sWordValid, sFirstWord;
   logic [5:0] rxBitPos;
   logic [4:0] sWord;

   // clock and random user bits
   always #20 core_clk = !core_clk;
   always @(negedge core_clk) txBitIn <= 1'($urandom);

   s_line_unit i_s_line_unit (.core_clk, .arst_n, .clkEn, .rxPins, .bitStrobe, .txPins, .rxBit,
      .rxBitValid, .rxBitPos, .frameLocked, .anySignal, .codeViolation, .collision, .txBitIn,
      .txBitTake, .mfEnable, .actF6F7, .qBits, .mfSynced, .mfChange, .sWord, .sWordValid,
      .sFirstWord);
   s_line_nt i_s_line_nt (.core_clk, .txPins, .rxPins, .bitStrobe, .mfBad, .echoBad,
      .quietZeros);

   task automatic check(input logic [5:0] seen, input logic [5:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic frames(input int k);
      repeat (k) @(i_s_line_nt.frameNo);
   endtask

   // bench model: bits and s bits as sent
   always @(posedge core_clk) if (arst_n && bitStrobe) begin
      expQ.push_back(i_s_line_nt.bitNow);
      violQ.push_back(i_s_line_nt.pos == 0);
      posQ.push_back((i_s_line_nt.pos + 1) % 48);
      if (i_s_line_nt.pos == 35) begin
         sQ.push_back(i_s_line_nt.bitNow);
         sFrQ.push_back(i_s_line_nt.frameNo);
      end
   end

   // compare design results with the model
   always @(negedge core_clk) if (arst_n) begin
      if (rxBitValid === 1'b1 && expQ.size() > 0) begin
         eb = expQ.pop_front();
         ev = violQ.pop_front();
         ep = posQ.pop_front();
         if (armed) begin
            check(rxBit, eb);
            check(codeViolation, ev);
            check(rxBitPos, 6'(ep));
         end
      end
      if (collision === 1'b1) nColl++;
      if (mfChange === 1'b1) nChange++;
      if (sWordValid === 1'b1) begin
         n = sQ.size();
         check(sWord, {sQ[n-5], sQ[n-4], sQ[n-3], sQ[n-2], sQ[n-1]});
         check(sFirstWord, sFrQ[n-5] % 20 == 0);
      end
   end

   // cycle ceiling
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 100000) begin
         n_fail++;
         conclude();
      end
   end

   // test sequence
   initial begin
      void'($urandom(32'h5AE57336));
      repeat (10) @(negedge core_clk);
      arst_n = 1'b1;
      frames(3);
      armed = 1'b1;
      bad0 = i_s_line_nt.txBadLen;
      // two then three marks per frame
      quietZeros = 1;
      frames(2);
      check(anySignal, 1'b0);
      check(frameLocked, 1'b1);
      quietZeros = 2;
      frames(2);
      check(anySignal, 1'b1);
      quietZeros = 0;
      // echo matches, then echo inverted
      frames(1);
      nColl = 0;
      frames(3);
      check(nColl == 0, 1'b1);
      echoBad = 1'b1;
      frames(2);
      echoBad = 1'b0;
      check(nColl > 0, 1'b1);
      frames(1);
      // hunting with idle q, then sync
      while (i_s_line_nt.frameNo % 20 != 7) frames(1);
      mfEnable = 1'b1;
      nChange = 0;
      frames(2);
      q1 = i_s_line_nt.qOnes;
      q0 = i_s_line_nt.qZeros;
      frames(53);
      check(mfSynced, 1'b0);
      check(i_s_line_nt.qZeros == q0, 1'b1);
      check(i_s_line_nt.qOnes - q1 > 50, 1'b1);
      frames(25);
      check(mfSynced, 1'b1);
      check(nChange == 1, 1'b1);
      q1 = i_s_line_nt.qOnes;
      q0 = i_s_line_nt.qZeros;
      frames(40);
      check(i_s_line_nt.qOnes - q1 == 4, 1'b1);
      check(i_s_line_nt.qZeros - q0 == 36, 1'b1);
      // bad multiframes, resync, leave active state
      mfBad = 1'b1;
      frames(40);
      check(mfSynced, 1'b1);
      frames(40);
      check(mfSynced, 1'b0);
      check(nChange == 2, 1'b1);
      mfBad = 1'b0;
      frames(80);
      check(mfSynced, 1'b1);
      actF6F7 = 1'b0;
      frames(1);
      check(mfSynced, 1'b0);
      check(nChange == 4, 1'b1);
      mfEnable = 1'b0;
      actF6F7 = 1'b1;
      frames(2);
      check(mfSynced, 1'b0);
      check(i_s_line_nt.txBadLen == bad0, 1'b1);
      check(i_s_line_nt.txViol > 200, 1'b1);
      conclude();
   end
endmodule // tb_top

bind s_line_unit s_line_unit_asserts i_s_line_unit_asserts (.core_clk, .arst_n, .clkEn,
   .bitStrobe, .mfEnable, .actF6F7, .txPins, .rxBit, .rxBitValid, .frameLocked, .anySignal,
   .codeViolation, .collision, .txBitTake, .mfSynced, .mfChange, .sWordValid, .sFirstWord);
